// ---- inc/ast_pkg.sv ----
// Package for the asynchronous serial transmitter: map, fields, states
package ast_pkg;

    // Register offsets on the plain register port (word index)
    localparam logic [3:0] AST_ADDR_CTRL = 4'h0;
    localparam logic [3:0] AST_ADDR_DATA = 4'h1;
    localparam logic [3:0] AST_ADDR_STATUS = 4'h2;
    localparam logic [3:0] AST_ADDR_BAUD = 4'h3;

    // Register data width
    localparam int AST_DW = 16;

    // Control field positions
    localparam int AST_CTRL_TX_EN_POS = 0;
    localparam int AST_CTRL_SYNC_POS = 1;
    localparam int AST_CTRL_PORT_EN_POS = 2;
    localparam int AST_CTRL_POL_POS = 3;
    localparam int AST_CTRL_NINE_POS = 4;
    localparam int AST_CTRL_IRQ_EN_POS = 5;
    localparam int AST_CTRL_BIT9_POS = 6;
    localparam int AST_CTRL_BRG16_POS = 7;

    // Status field positions
    localparam int AST_STAT_FLAG_POS = 0;
    localparam int AST_STAT_HOLD_POS = 1;
    localparam int AST_STAT_BUSY_POS = 2;

    // Reset values
    localparam logic [15:0] AST_CTRL_RST = 16'h0000;
    localparam logic [15:0] AST_BAUD_RST = 16'h0000;

    // Index of the last data bit per frame
    localparam logic [3:0] AST_BITS8_LAST = 4'h7;
    localparam logic [3:0] AST_BITS9_LAST = 4'h8;

    // Control register layout, most significant field first
    typedef struct packed {
        logic [7:0] rsvd;     // Stored and read back as written
        logic brg16;          // 1: full 16-bit divisor, 0: low 8 bits
        logic bit9;           // Ninth data bit captured with a character
        logic irq_en;         // tx_irq_enable
        logic nine;           // 1: nine data bits per frame
        logic pol;            // tx_polarity_bit
        logic port_en;        // port_enable_bit
        logic sync;           // Synchronous select
        logic tx_en;          // tx_enable_bit
    } ast_ctrl_t;

    // Transmitter states
    typedef enum logic [1:0] {
        AST_IDLE,
        AST_START,
        AST_DATA,
        AST_STOP
    } ast_state_t;

endpackage : ast_pkg

// ---- rtl/ast_tx.sv ----
// Asynchronous serial transmitter with holding and shift registers
`timescale 1ns/1ps
`default_nettype none

module ast_tx
    import ast_pkg::*;
(
    input wire logic clk_in,                    // System clock, 125 MHz
    input wire logic rstn_in,                   // Async reset, active low
    input wire logic [3:0] addr_in,             // Register index
    input wire logic [AST_DW-1:0] wdata_in,     // Write data
    input wire logic wr_in,                     // Write strobe
    input wire logic rd_in,                     // Read strobe
    output logic [AST_DW-1:0] rdata_out,        // Read data, next cycle
    output logic tx_clock_pin_out,              // Serial line level
    output logic tx_clock_pin_oe_out,           // Pin driven while high
    output logic irq_out                        // Buffer-empty request
);

    // Divisor in use: 8-bit or 16-bit generator
    function automatic logic [15:0] brg_div(input ast_ctrl_t c,
                                            input logic [15:0] b);
        brg_div = c.brg16 ? b : {8'h00, b[7:0]};
    endfunction : brg_div

    // Software-visible state
    ast_ctrl_t ctrl;                 // Control register
    ast_ctrl_t next_ctrl;
    logic [15:0] baud;               // Bit period minus one, in cycles
    logic [15:0] next_baud;
    logic [AST_DW-1:0] next_rdata;
    logic flag;                      // tx_buffer_empty_flag
    logic next_flag;

    // Transmitter state
    ast_state_t state;
    ast_state_t next_state;
    logic [8:0] hold;                // tx_holding_reg with ninth bit
    logic [8:0] next_hold;
    logic hold_full;                 // A character waits in hold
    logic next_hold_full;
    logic [8:0] shift;               // tx_shift_reg, no software path
    logic [8:0] next_shift;
    logic [3:0] bits;                // Data bit index
    logic [3:0] next_bits;
    logic [15:0] cnt;                // Baud down-counter
    logic [15:0] next_cnt;
    logic line;                      // Registered pin level
    logic next_line;

    // Decoded controls
    logic async_on;                  // Async transmitter active
    logic tick;                      // End of a bit period
    logic wr_data;                   // Character write accepted
    logic [3:0] last_bit;            // Index of final data bit
    logic logical;                   // Unpolarised next line value

    assign async_on = ctrl.tx_en & ~ctrl.sync & ctrl.port_en;
    assign tick = (cnt == 16'h0000);
    assign wr_data = wr_in & (addr_in == AST_ADDR_DATA) & async_on;
    assign last_bit = ctrl.nine ? AST_BITS9_LAST : AST_BITS8_LAST;

    // Pin drive and interrupt request
    assign tx_clock_pin_oe_out = ctrl.port_en;
    assign tx_clock_pin_out = line;
    assign irq_out = flag & ctrl.irq_en;

    // Register file next values and read mux
    always_comb begin
        next_ctrl = ctrl;
        next_baud = baud;
        next_rdata = '0;
        // Flag follows the holding state of the previous cycle
        next_flag = async_on & ~hold_full;
        if (wr_in) begin
            unique case (addr_in)
                AST_ADDR_CTRL: next_ctrl = ast_ctrl_t'(wdata_in);
                AST_ADDR_BAUD: next_baud = wdata_in;
                default: begin
                    // Status writes are dropped: flag is read-only
                end
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                AST_ADDR_CTRL: next_rdata = ctrl;
                AST_ADDR_DATA: next_rdata = {7'h00, hold};
                AST_ADDR_STATUS: begin
                    next_rdata[AST_STAT_FLAG_POS] = flag;
                    next_rdata[AST_STAT_HOLD_POS] = hold_full;
                    next_rdata[AST_STAT_BUSY_POS] = (state != AST_IDLE);
                end
                AST_ADDR_BAUD: next_rdata = baud;
                default: next_rdata = '0;        // Unmapped reads zero
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= ast_ctrl_t'(AST_CTRL_RST);
            baud <= AST_BAUD_RST;
            rdata_out <= '0;
            flag <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            baud <= next_baud;
            rdata_out <= next_rdata;
            flag <= next_flag;
        end
    end

    // Transmitter next-state logic
    always_comb begin
        next_state = state;
        next_hold = hold;
        next_hold_full = hold_full;
        next_shift = shift;
        next_bits = bits;
        next_cnt = cnt;
        logical = 1'b1;
        if (!async_on) begin
            // Disabled: everything empty, line at idle
            next_state = AST_IDLE;
            next_hold_full = 1'b0;
        end else begin
            if (state != AST_IDLE) begin
                next_cnt = tick ? brg_div(ctrl, baud) : cnt - 16'h0001;
            end
            unique case (state)
                AST_IDLE: begin
                    if (hold_full) begin
                        // Shifter empty: load at once
                        next_shift = hold;
                        next_hold_full = 1'b0;
                        next_state = AST_START;
                        next_cnt = brg_div(ctrl, baud);
                    end
                end
                AST_START: begin
                    if (tick) begin
                        next_state = AST_DATA;
                        next_bits = 4'h0;
                    end
                end
                AST_DATA: begin
                    if (tick) begin
                        // Least significant bit first
                        next_shift = {1'b0, shift[8:1]};
                        next_bits = bits + 4'h1;
                        if (bits == last_bit) begin
                            next_state = AST_STOP;
                        end
                    end
                end
                AST_STOP: begin
                    if (tick) begin
                        if (hold_full) begin
                            // Waiting character loads right after stop
                            next_shift = hold;
                            next_hold_full = 1'b0;
                            next_state = AST_START;
                        end else begin
                            next_state = AST_IDLE;
                        end
                    end
                end
            endcase
            // New character lands in hold; it waits if shifter busy
            if (wr_data) begin
                next_hold = {ctrl.bit9, wdata_in[7:0]};
                next_hold_full = 1'b1;
            end
        end
        // Line level from the next frame position
        unique case (next_state)
            AST_START: logical = 1'b0;
            AST_DATA: logical = next_shift[0];
            default: logical = 1'b1;
        endcase
        // Inversion only in async operation
        next_line = logical ^ (ctrl.pol & ~ctrl.sync);
    end

    // Transmitter flops
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= AST_IDLE;
            hold <= '0;
            hold_full <= 1'b0;
            shift <= '0;
            bits <= '0;
            cnt <= '0;
            line <= 1'b1;
        end else begin
            state <= next_state;
            hold <= next_hold;
            hold_full <= next_hold_full;
            shift <= next_shift;
            bits <= next_bits;
            cnt <= next_cnt;
            line <= next_line;
        end
    end

    // Checks on the transmitter behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // A stop bit ends while a character waits
    sequence s_stop_end_queued;
        state == AST_STOP && tick && hold_full && async_on && !wr_data;
    endsequence

    // A character written into an empty hold, transmitter kept on
    sequence s_write_empty;
        wr_data && !hold_full ##1 async_on;
    endsequence

    a_disabled_empty: assert property (
        !async_on |=> state == AST_IDLE && !hold_full && !flag)
        else $error("disabled transmitter not empty");

    a_pin_output: assert property (
        $rose(ctrl.port_en) |-> tx_clock_pin_oe_out)
        else $error("pin not output after port enable");

    a_flag_on_enable: assert property (
        $rose(async_on) |=> flag)
        else $error("flag not set after enable");

    a_idle_load: assert property (
        state == AST_IDLE && hold_full && async_on
        |=> state == AST_START && line == $past(ctrl.pol))
        else $error("idle shifter did not load and start");

    a_hold_waits: assert property (
        hold_full && async_on && state != AST_IDLE
        && !(state == AST_STOP && tick) ##1 async_on |-> hold_full)
        else $error("queued character lost before stop");

    a_stop_reload: assert property (
        s_stop_end_queued |=> state == AST_START && !hold_full)
        else $error("queued character not loaded after stop");

    a_idle_level: assert property (
        state == AST_IDLE && $past(state) == AST_IDLE
        && $stable(ctrl) |-> line == ~(ctrl.pol & ~ctrl.sync))
        else $error("idle level wrong for polarity");

    a_flag_delay: assert property (
        s_write_empty |-> flag ##1 (!async_on || !flag
        || state == AST_IDLE || !hold_full))
        else $error("flag timing after write wrong");

    a_irq_gate: assert property (
        !ctrl.irq_en |-> !irq_out)
        else $error("interrupt raised while disabled");

    a_bit_period: assert property (
        state == AST_START && $past(state) == AST_IDLE
        && brg_div(ctrl, baud) == 16'h0002 && $stable(baud)
        |-> state == AST_START [*3] ##1 state == AST_DATA)
        else $error("start bit length wrong");

    a_start_space: assert property (
        state == AST_START && $stable(ctrl)
        |-> line == ctrl.pol)
        else $error("start bit not at space level");

    a_stop_mark: assert property (
        state == AST_STOP && $stable(ctrl)
        |-> line == ~ctrl.pol)
        else $error("stop bit not at mark level");

    a_shift_source: assert property (
        state == AST_IDLE && hold_full && async_on
        |=> shift == $past(hold))
        else $error("shift register not loaded from hold");

endmodule : ast_tx

`default_nettype wire

// ---- testbench/ast_rx_model.sv ----
// Remote receiver model that samples the serial line in mid-bit
`timescale 1ns/1ps
`default_nettype none

module ast_rx_model (
    input wire logic clk_in,         // System clock
    input wire logic line_in,        // Line level at the far end
    input wire logic pol_in,         // 1: inverted stream
    input wire logic nine_in,        // 1: nine data bits
    input wire logic [7:0] div_in,   // Bit period minus one
    output var logic start_out,      // Pulse after a start edge
    output var logic valid_out,      // Pulse with a character
    output var logic [8:0] data_out, // Received character
    output var logic stop_ok_out     // Stop bit seen at mark
);
    int p; // Bit period in cycles

    initial begin
        start_out = 1'b0;
        valid_out = 1'b0;
        data_out = '0;
        stop_ok_out = 1'b0;
    end

    // Hunt for a space, then sample each bit in its middle
    always begin
        @(posedge clk_in);
        valid_out <= 1'b0;
        if ((line_in ^ pol_in) === 1'b0) begin
            p = int'(div_in) + 1;
            start_out <= 1'b1;
            @(posedge clk_in);
            start_out <= 1'b0;
            repeat (p / 2 - 1) @(posedge clk_in);
            data_out <= '0;
            for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
                repeat (p) @(posedge clk_in);
                data_out[i] <= line_in ^ pol_in;
            end
            repeat (p) @(posedge clk_in);
            stop_ok_out <= (line_in ^ pol_in) === 1'b1;
            valid_out <= 1'b1;
        end
    end
endmodule : ast_rx_model
`default_nettype wire

// ---- testbench/async_serial_transmitter_test.sv ----
// Self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none

module async_serial_transmitter_test;
    import ast_pkg::*;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0; // Bus and reset
    logic [3:0] addr_in = '0;
    logic [15:0] wdata_in = '0, rdata_out, d;
    logic pin, oe, irq, rx_start, rx_valid, rx_stop; // Design and far end
    logic [8:0] rx_data;
    logic pol = 0, nine = 0, discard = 1, b9; // Model settings
    logic [7:0] dv = 8'h01, c;
    int n_errors = 0, n_checks = 0, cyc = 0;
    int st_q[$];          // Cycles at which frames started
    logic [8:0] exp_q[$]; // Characters still expected at the far end

    // Clock, 8 ns period
    always #4 clk_in = ~clk_in;

    ast_tx u_ast_tx (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .tx_clock_pin_out(pin),
        .tx_clock_pin_oe_out(oe), .irq_out(irq));
    // Released line is pulled up
    ast_rx_model u_ast_rx_model (.clk_in(clk_in),
        .line_in(oe ? pin : 1'b1), .pol_in(pol), .nine_in(nine),
        .div_in(dv), .start_out(rx_start), .valid_out(rx_valid),
        .data_out(rx_data), .stop_ok_out(rx_stop));

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        n_checks++;
        if (seen !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        d = rdata_out;
    endtask : rd

    function automatic logic [15:0] ctl(logic p, logic n, logic i, logic b);
        return 16'h0005 | (16'(p) << AST_CTRL_POL_POS)
            | (16'(n) << AST_CTRL_NINE_POS) | (16'(i) << AST_CTRL_IRQ_EN_POS)
            | (16'(b) << AST_CTRL_BIT9_POS);
    endfunction : ctl

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Reference side: compare every character received while discard is clear with the queue
    always @(posedge clk_in) begin
        cyc++;
        if (rx_start && !discard) st_q.push_back(cyc);
        if (rx_valid && !discard) begin
            if (exp_q.size() == 0) begin
                chk("unexpected frame", 16'h0001, 16'h0000);
            end else begin
                chk("char", 16'(rx_data), 16'(exp_q.pop_front()));
                chk("stop bit", 16'(rx_stop), 16'h0001);
            end
        end
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(32'h2fef_4922));
        repeat (2) @(negedge clk_in);
        chk("pin in reset", 16'(pin), 16'h0001);
        chk("oe in reset", 16'(oe), 16'h0000);
        chk("irq in reset", 16'(irq), 16'h0000);
        @(posedge clk_in);
        rstn_in <= 1'b1;
        discard = 0;
        rd(AST_ADDR_CTRL);
        chk("ctrl reset", d, 16'h0000);
        rd(AST_ADDR_STATUS);
        chk("status off", d, 16'h0000);
        $display("test reset done");
        // Synchronous select with inverted polarity: nothing goes out
        wr(AST_ADDR_CTRL, 16'h000f);
        wr(AST_ADDR_DATA, 16'h00a5);
        repeat (40) @(posedge clk_in);
        @(negedge clk_in);
        chk("sync pin", 16'(pin), 16'h0001);
        chk("sync oe", 16'(oe), 16'h0001);
        rd(AST_ADDR_STATUS);
        chk("sync hold", d & 16'h0002, 16'h0000);
        $display("test sync done");
        // Every polarity and length, two characters back to back
        for (int k = 0; k < 4; k++) begin
            discard = 1;
            dv = (k == 0) ? 8'h02 : 8'($urandom_range(3, 1));
            b9 = 1'($urandom);
            wr(AST_ADDR_BAUD, {8'h00, dv});
            wr(AST_ADDR_CTRL, ctl(k[0], k[1], 1'b1, b9));
            pol = k[0];
            nine = k[1];
            repeat (60) @(posedge clk_in);
            discard = 0;
            st_q.delete();
            @(negedge clk_in);
            chk("idle level", 16'(pin), 16'(!pol));
            chk("irq enabled", 16'(irq), 16'h0001);
            rd(AST_ADDR_STATUS);
            chk("flag on enable", d, 16'h0001);
            for (int j = 0; j < 2; j++) begin
                c = 8'($urandom);
                exp_q.push_back(nine ? {b9, c} : {1'b0, c});
                wr(AST_ADDR_DATA, {8'h00, c});
            end
            // Last character written: interrupt enable dropped
            wr(AST_ADDR_CTRL, ctl(pol, nine, 1'b0, b9));
            rd(AST_ADDR_STATUS);
            chk("queued status", d, 16'h0006);
            chk("irq masked", 16'(irq), 16'h0000);
            for (int w = 0; w < 400 && exp_q.size() > 0; w++) begin
                @(posedge clk_in);
            end
            chk("left over", 16'(exp_q.size()), 16'h0000);
            if (st_q.size() < 2) st_q = '{0, 0};
            chk("frame spacing", 16'(st_q[1] - st_q[0]),
                16'((nine ? 11 : 10) * (int'(dv) + 1)));
            wr(AST_ADDR_STATUS, 16'h0000);
            repeat (2 * (int'(dv) + 1)) @(posedge clk_in);
            rd(AST_ADDR_STATUS);
            chk("flag after writes", d, 16'h0001);
            chk("irq off, flag set", 16'(irq), 16'h0000);
            $display("test config %0d done", k);
        end
        // Disable in mid-frame
        discard = 1;
        wr(AST_ADDR_DATA, 16'(8'($urandom)));
        repeat (10) @(posedge clk_in);
        wr(AST_ADDR_CTRL, 16'h0004);
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk("disabled pin", 16'(pin), 16'h0001);
        rd(AST_ADDR_STATUS);
        chk("disabled status", d, 16'h0000);
        $display("test disable done");
        test_done();
    end
endmodule : async_serial_transmitter_test
`default_nettype wire
